// ==== rtl/mac_map.svh ====
/*
  constants of the margin adjust control block: register offsets, reset
  codes and printed times. assumes the 10 MHz block clock.
*/
`ifndef MAC_MAP_SVH
`define MAC_MAP_SVH
// ----------------------------------------
// codes and offsets
// ----------------------------------------
`define MAC_ZERO_CODE  8'h80
`define MAC_CODE_MIN   8'h00
`define MAC_CODE_MAX   8'hff
`define MAC_READ_FILL  8'hff
`define MAC_REG_RESET  8'h12
`define MAC_REG_TRIM1  8'h13
`define MAC_REG_TRIM8  8'h1a
`define MAC_SYNC_INIT  6'h31
// ----------------------------------------
// times in ns
// ----------------------------------------
`define MAC_CLK_NS     100
`define MAC_UPD0_NS    580000
`define MAC_UPD1_NS    1150000
`define MAC_UPD2_NS    9220000
`define MAC_UPD3_NS    18500000
`define MAC_CAL_NS     2500000
`define MAC_SMB_TO_NS  25000000
`endif

// ==== rtl/mac_pkg.sv ====
/*
  types of the margin adjust control block.
  assumes mac_map.svh supplies the numbers.
*/
package mac_pkg;
  // per-cell profile-zero source
  typedef enum logic [1:0] {
    MAC_MODE_NV0 = 2'b00,
    MAC_MODE_I2C = 2'b01,
    MAC_MODE_CL  = 2'b10
  } mac_mode_e;
  // serial slave states
  typedef enum logic [1:0] {
    MAC_ST_IDLE = 2'b00,
    MAC_ST_RX   = 2'b01,
    MAC_ST_TX   = 2'b10,
    MAC_ST_IGN  = 2'b11
  } mac_st_e;
  // non-volatile setup of one cell
  typedef struct packed {
    mac_mode_e       mode;
    logic            pol;
    logic [9:0]      setpoint;
    logic [3:0][7:0] dac;
  } mac_cell_nv_s;
  // one adc result
  typedef struct packed {
    logic       valid;
    logic [3:0] chan;
    logic [9:0] code;
  } mac_adc_s;
endpackage : mac_pkg

// ==== rtl/mac_trim_ctrl.sv ====
/*
  margin adjust control: profile/mode selection, closed-loop trim,
  serial slave for trim codes and reset, device reset sequencing.
  assumes nv settings are static, adc results and logic signals are on
  clk_i, and scl/sda/reset/jtag/profile pins are asynchronous.
*/
`include "mac_map.svh"
// Overview of operation
// R01 - in profile zero each of eight cells uses its own stored mode
// R02 - stored mode loads profile-zero stored code in the normal profile
// R03 - serial trim register resets to 80h, host writes drive dac in that mode
// R04 - host writes the serial code before enabling the trimmed supply
// R05 - compare measurement with setpoint giving +1, -1 or 0
// R06 - loop register steps by comparison and polarity, holds on zero
// R07 - rate code 00..11 gives 580us, 1.15ms, 9.22ms, 18.5ms intervals
// R08 - cell n always uses monitor input n
// R09 - loop runs only while the shared logic enable is high
// R10 - loop register resets to 80h, preloadable at the serial trim address
// R11 - dac code is eight bits, 80h is bipolar zero
// R12 - offset choice is latched and not changeable while running
// R13 - in reset low outputs float, open-drain float, gate drivers pull down
// R14 - after reset outputs resume, sequence restarts, 2.5ms calibration
// R15 - reset pin, jtag or serial reset return device to power-on state
// R16 - serial port is a 7-bit addressed slave only, address from jtag
// R17 - serial port supports smbus timeout and alert
// R18 - integrator avoids reserved slave addresses
// R19 - profile bits come from pins or logic by stored choice
// R20 - profile 11, 10, 01 select stored codes 3, 2, 1 for all cells
// R21 - loop register saturates at 00h and ffh
module mac_trim_ctrl #(
  parameter int NCELL   = 8,
  parameter int UPD0_CYC = `MAC_UPD0_NS / `MAC_CLK_NS,
  parameter int UPD1_CYC = `MAC_UPD1_NS / `MAC_CLK_NS,
  parameter int UPD2_CYC = `MAC_UPD2_NS / `MAC_CLK_NS,
  parameter int UPD3_CYC = `MAC_UPD3_NS / `MAC_CLK_NS,
  parameter int CAL_CYC  = `MAC_CAL_NS / `MAC_CLK_NS,
  parameter int TO_CYC   = `MAC_SMB_TO_NS / `MAC_CLK_NS
) (
  // clock and reset
  input  wire logic                              clk_i,
  input  wire logic                              rst_i,
  input  wire logic                              ce_i,
  // asynchronous reset sources
  input  wire logic                              active_low_reset_pin_i,
  input  wire logic                              jtag_reset_i,
  // profile and loop control
  input  wire logic                              profile_select_pin_0_i,
  input  wire logic                              profile_select_pin_1_i,
  input  wire logic                              logic_profile_select_0_i,
  input  wire logic                              logic_profile_select_1_i,
  input  wire logic                              closed_loop_enable_i,
  // non-volatile setup
  input  wire logic                              nv_profile_from_logic_i,
  input  wire logic [1:0]                        nv_update_rate_i,
  input  wire logic [1:0]                        nv_offset_sel_i,
  input  wire mac_pkg::mac_cell_nv_s [NCELL-1:0] nv_cell_i,
  input  wire logic [6:0]                        slave_addr_i,
  // measurement
  input  wire mac_pkg::mac_adc_s                 adc_i,
  // serial bus
  input  wire logic                              scl_i,
  input  wire logic                              sda_i,
  output logic                                   sda_o,
  output logic                                   sda_oe_o,
  input  wire logic                              alert_req_i,
  output logic                                   alert_o,
  output logic                                   alert_oe_o,
  // configured output states
  input  wire logic [15:0]                       lv_level_i,
  input  wire logic [3:0]                        hv_level_i,
  input  wire logic [3:0]                        hv_fet_mode_i,
  output logic [15:0]                            low_voltage_outputs_oe_o,
  output logic [3:0]                             high_voltage_output_o,
  output logic [3:0]                             high_voltage_output_oe_o,
  // trim results
  output logic [NCELL-1:0][7:0]                  dac_code_o,
  output logic                                   dac_ready_o,
  output logic [1:0]                             offset_sel_o,
  output logic                                   seq_restart_o
);
  import mac_pkg::*;

  // ----------------------------------------
  // functions
  // ----------------------------------------
  // three-state compare: 01 = +1, 11 = -1, 00 = 0
  function automatic logic [1:0] cmp3(input logic [9:0] sp, input logic [9:0] m);
    cmp3 = (sp > m) ? 2'b01 : (sp < m) ? 2'b11 : 2'b00; // R05
  endfunction : cmp3

  // saturating step of the loop register
  function automatic logic [7:0] step(input logic [7:0] v, input logic [1:0] c,
                                      input logic pol);
    logic up;
    logic dn;
    up = (c == 2'b01) ^ (pol && c != 2'b00);
    dn = (c != 2'b00) && !up;
    if (up && v != `MAC_CODE_MAX) step = v + 8'h01; // R06 R21
    else if (dn && v != `MAC_CODE_MIN) step = v - 8'h01;
    else step = v;
  endfunction : step

  // ----------------------------------------
  // input synchronisers
  // ----------------------------------------
  logic [5:0] s1_q;
  logic [5:0] s2_q;
  logic [1:0] s3_q;
  wire  [5:0] raw = {scl_i, sda_i, profile_select_pin_1_i, profile_select_pin_0_i,
                     jtag_reset_i, active_low_reset_pin_i};
  // third stage only feeds edge detection of scl/sda
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s1_q <= `MAC_SYNC_INIT;
      s2_q <= `MAC_SYNC_INIT;
      s3_q <= 2'b11;
    end else if (ce_i) begin
      s1_q <= raw;
      s2_q <= s1_q;
      s3_q <= s2_q[5:4];
    end
  end
  wire scl   = s2_q[5];
  wire sda   = s2_q[4];
  wire rise  = scl && !s3_q[1];
  wire fall  = !scl && s3_q[1];
  wire start = scl && s3_q[1] && !sda && s3_q[0];
  wire stop  = scl && s3_q[1] && sda && !s3_q[0];

  // ----------------------------------------
  // device reset and calibration
  // ----------------------------------------
  logic        dev_rst_q;
  logic [17:0] cal_q;
  logic        soft_pend_q;
  wire         soft_go = soft_pend_q && stop;
  wire         cal_end = cal_q == 18'(CAL_CYC - 1);
  // any source returns trim, calibration and bus state to power-on; meas_q and ptr_q keep their values
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      dev_rst_q     <= 1'b1;
      cal_q         <= '0;
      dac_ready_o   <= 1'b0;
      seq_restart_o <= 1'b0;
      offset_sel_o  <= '0;
    end else if (ce_i) begin
      dev_rst_q     <= !s2_q[0] || s2_q[1] || soft_go; // R15
      seq_restart_o <= dev_rst_q && !(!s2_q[0] || s2_q[1] || soft_go); // R14
      if (dev_rst_q) begin
        cal_q         <= '0;
        dac_ready_o   <= 1'b0;
        offset_sel_o  <= nv_offset_sel_i; // R12
      end else if (!dac_ready_o) begin
        cal_q       <= cal_q + 18'h1;
        dac_ready_o <= cal_end; // R14
      end
    end
  end

  // ----------------------------------------
  // output pins
  // ----------------------------------------
  // gate drivers pull down in reset; everything else floats
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      low_voltage_outputs_oe_o <= '0;
      high_voltage_output_o    <= '0;
      high_voltage_output_oe_o <= '0;
    end else if (ce_i) begin
      low_voltage_outputs_oe_o <= dev_rst_q ? '0 : ~lv_level_i; // R13
      high_voltage_output_o    <= dev_rst_q ? '0 : hv_level_i & hv_fet_mode_i;
      high_voltage_output_oe_o <= dev_rst_q ? hv_fet_mode_i
                                            : hv_fet_mode_i | ~hv_level_i; // R13
    end
  end

  // ----------------------------------------
  // serial slave
  // ----------------------------------------
  mac_st_e     st_q;
  logic [3:0]  bit_q;
  logic [1:0]  byte_q;
  logic        rw_q;
  logic        nack_q;
  logic [7:0]  sh_q;
  logic [7:0]  ptr_q;
  logic [7:0]  tx_q;
  logic [17:0] to_q;
  logic [NCELL-1:0][7:0] i2c_q;
  logic [NCELL-1:0][7:0] cl_q;
  wire         to_hit  = to_q == 18'(TO_CYC - 1);
  wire         in_trim = ptr_q >= `MAC_REG_TRIM1 && ptr_q <= `MAC_REG_TRIM8;
  wire  [7:0]  pidx    = ptr_q - `MAC_REG_TRIM1;
  wire  [2:0]  cidx    = pidx[2:0];
  wire  [7:0]  rd_byte = !in_trim ? `MAC_READ_FILL
                       : (nv_cell_i[cidx].mode == MAC_MODE_CL) ? cl_q[cidx]
                       : i2c_q[cidx];
  wire         rx_ack  = fall && st_q == MAC_ST_RX && bit_q == 4'd8;
  wire         wr_fire = rx_ack && byte_q == 2'd2 && !rw_q;
  wire         adr_ok  = sh_q[7:1] == slave_addr_i; // R16
  // slave only: sda is driven for ack and read data, never to start
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_q <= MAC_ST_IDLE;
      bit_q <= '0;
      byte_q <= '0;
      rw_q <= 1'b0;
      nack_q <= 1'b0;
      sh_q <= '0;
      ptr_q <= '0;
      tx_q <= '0;
      sda_oe_o <= 1'b0;
    end else if (ce_i) begin
      if (dev_rst_q || to_hit || stop) begin // R17
        st_q <= MAC_ST_IDLE;
        sda_oe_o <= 1'b0;
      end else if (start) begin
        st_q <= MAC_ST_RX;
        bit_q <= '0;
        byte_q <= '0;
        sda_oe_o <= 1'b0;
      end else if (rise) begin
        if (st_q == MAC_ST_RX && bit_q < 4'd8) begin
          sh_q  <= {sh_q[6:0], sda};
          bit_q <= bit_q + 4'd1;
        end else if (st_q == MAC_ST_TX && bit_q < 4'd9) begin
          nack_q <= sda;
          bit_q  <= bit_q + 4'd1;
        end
      end else if (fall) begin
        case (st_q)
          MAC_ST_RX: begin
            if (bit_q == 4'd8) begin
              if (byte_q == 2'd0 && !adr_ok) st_q <= MAC_ST_IGN; // R16
              else begin
                sda_oe_o <= 1'b1;
                bit_q    <= 4'd9;
              end
              if (byte_q == 2'd0) rw_q <= sh_q[0];
              if (byte_q == 2'd1) ptr_q <= sh_q;
            end else if (bit_q == 4'd9) begin
              bit_q  <= '0;
              byte_q <= (byte_q == 2'd2) ? byte_q : byte_q + 2'd1;
              if (rw_q) begin
                st_q     <= MAC_ST_TX;
                tx_q     <= rd_byte;
                sda_oe_o <= !rd_byte[7];
              end else sda_oe_o <= 1'b0;
            end
          end
          MAC_ST_TX: begin
            if (bit_q < 4'd8) begin
              tx_q     <= {tx_q[6:0], 1'b1};
              sda_oe_o <= !tx_q[6];
            end else if (bit_q == 4'd8) sda_oe_o <= 1'b0;
            else if (nack_q) st_q <= MAC_ST_IGN;
            else begin
              tx_q     <= rd_byte;
              sda_oe_o <= !rd_byte[7];
              bit_q    <= '0;
            end
          end
          default: ;
        endcase
      end
    end
  end

  // smbus timeout on a long low clock, alert mirrored open-drain
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      to_q        <= '0;
      soft_pend_q <= 1'b0;
      alert_oe_o  <= 1'b0;
    end else if (ce_i) begin
      to_q        <= (st_q == MAC_ST_IDLE || scl || to_hit) ? '0 : to_q + 18'h1; // R17
      soft_pend_q <= !dev_rst_q && (soft_pend_q || (wr_fire && ptr_q == `MAC_REG_RESET));
      alert_oe_o  <= alert_req_i && !dev_rst_q; // R17
    end
  end
  assign sda_o   = 1'b0;
  assign alert_o = 1'b0;

  // ----------------------------------------
  // profile and closed loop
  // ----------------------------------------
  logic [NCELL-1:0][9:0] meas_q;
  logic [17:0]           upd_q;
  wire  [1:0] prof = nv_profile_from_logic_i
                   ? {logic_profile_select_1_i, logic_profile_select_0_i}
                   : s2_q[3:2]; // R19
  wire  [17:0] upd_lim = (nv_update_rate_i == 2'b00) ? 18'(UPD0_CYC - 1)
                       : (nv_update_rate_i == 2'b01) ? 18'(UPD1_CYC - 1)
                       : (nv_update_rate_i == 2'b10) ? 18'(UPD2_CYC - 1)
                       : 18'(UPD3_CYC - 1); // R07
  wire         tick    = upd_q == upd_lim;
  wire         run     = tick && closed_loop_enable_i && dac_ready_o; // R09

  // interval timer and per-cell measurements
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      upd_q  <= '0;
      meas_q <= '0;
    end else if (ce_i) begin
      upd_q <= (dev_rst_q || tick) ? '0 : upd_q + 18'h1;
      if (adc_i.valid && adc_i.chan < 4'(NCELL))
        meas_q[adc_i.chan[2:0]] <= adc_i.code; // R08
    end
  end

  // trim registers and dac selection
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      i2c_q      <= {NCELL{`MAC_ZERO_CODE}};
      cl_q       <= {NCELL{`MAC_ZERO_CODE}};
      dac_code_o <= {NCELL{`MAC_ZERO_CODE}};
    end else if (ce_i) begin
      for (int n = 0; n < NCELL; n++) begin
        if (dev_rst_q) begin
          i2c_q[n]      <= `MAC_ZERO_CODE; // R03 R10
          cl_q[n]       <= `MAC_ZERO_CODE;
          dac_code_o[n] <= `MAC_ZERO_CODE; // R11
        end else begin
          if (wr_fire && in_trim && cidx == 3'(n)) begin
            if (nv_cell_i[n].mode == MAC_MODE_CL && !closed_loop_enable_i)
              cl_q[n] <= sh_q; // R10
            else i2c_q[n] <= sh_q; // R03
          end else if (run && nv_cell_i[n].mode == MAC_MODE_CL)
            cl_q[n] <= step(cl_q[n], cmp3(nv_cell_i[n].setpoint, meas_q[n]),
                            nv_cell_i[n].pol); // R06 R08
          if (!dac_ready_o) dac_code_o[n] <= `MAC_ZERO_CODE;
          else if (prof != 2'b00) dac_code_o[n] <= nv_cell_i[n].dac[prof]; // R20
          else case (nv_cell_i[n].mode) // R01
            MAC_MODE_I2C: dac_code_o[n] <= i2c_q[n]; // R03
            MAC_MODE_CL:  dac_code_o[n] <= cl_q[n];
            default:      dac_code_o[n] <= nv_cell_i[n].dac[0]; // R02
          endcase
        end
      end
    end
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  property p_hold;
    @(posedge clk_i) disable iff (rst_i)
    ce_i && !dev_rst_q && !wr_fire && cmp3(nv_cell_i[0].setpoint, meas_q[0]) == 2'b00
    |=> $stable(cl_q[0]);
  endproperty
  a_hold: assert property (p_hold) else $error("loop moved on equal"); // R06
  property p_sat;
    @(posedge clk_i) disable iff (rst_i)
    ce_i && !dev_rst_q && !wr_fire && cl_q[0] == `MAC_CODE_MAX |=> cl_q[0] != `MAC_CODE_MIN;
  endproperty
  a_sat: assert property (p_sat) else $error("loop wrapped"); // R21
  property p_zero;
    @(posedge clk_i) disable iff (rst_i)
    ce_i && dev_rst_q |=> i2c_q[0] == `MAC_ZERO_CODE && cl_q[0] == `MAC_ZERO_CODE;
  endproperty
  a_zero: assert property (p_zero) else $error("trim not zeroed"); // R03
  property p_prof;
    @(posedge clk_i) disable iff (rst_i)
    ce_i && dac_ready_o && !dev_rst_q && prof == 2'b11 |=> dac_code_o[1] == $past(nv_cell_i[1].dac[3]);
  endproperty
  a_prof: assert property (p_prof) else $error("profile code wrong"); // R20
  property p_lvz;
    @(posedge clk_i) disable iff (rst_i)
    ce_i && dev_rst_q |=> low_voltage_outputs_oe_o == '0;
  endproperty
  a_lvz: assert property (p_lvz) else $error("outputs not floating"); // R13
  property p_clen;
    @(posedge clk_i) disable iff (rst_i)
    ce_i && !closed_loop_enable_i && !dev_rst_q && !wr_fire |=> $stable(cl_q);
  endproperty
  a_clen: assert property (p_clen) else $error("loop ran disabled"); // R09
  property p_idle;
    @(posedge clk_i) disable iff (rst_i)
    ce_i && st_q == MAC_ST_IDLE && !start |=> !sda_oe_o;
  endproperty
  a_idle: assert property (p_idle) else $error("idle slave drove sda"); // R16
  property p_cal;
    @(posedge clk_i) disable iff (rst_i)
    ce_i && dev_rst_q |=> !dac_ready_o ##1 !dac_ready_o;
  endproperty
  a_cal: assert property (p_cal) else $error("ready too early"); // R14
endmodule : mac_trim_ctrl

// ==== tb/mac_i2c_host.sv ====
/*
  host side model: bit-level serial bus master on open-drain lines.
  assumes a pull-up, so a released line reads 1, and sda_i is the wired level.
*/
module mac_i2c_host (
  // clock used only to align bus edges
  input  wire logic clk_i,
  // bus lines
  input  wire logic sda_i,
  output logic      scl_o,
  output logic      sda_o
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam int HALF = 400; // 800 ns bus period
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  // start: sda falls while scl is high
  task automatic start_c();
    @(negedge clk_i);
    sda_o = 1'b1;
    scl_o = 1'b1;
    #HALF sda_o = 1'b0;
    #HALF scl_o = 1'b0;
  endtask : start_c
  // data moves mid-low, well clear of the synchronised scl fall
  task automatic bit_c(input logic b, output logic s);
    #(HALF / 2) sda_o = b;
    #(HALF / 2) scl_o = 1'b1;
    #(HALF / 2) s = sda_i;
    #(HALF / 2) scl_o = 1'b0;
  endtask : bit_c
  // msb first, ninth bit released for the slave; 0 = taken
  task automatic put_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_c(b[i], s);
    bit_c(1'b1, ack);
  endtask : put_byte
  task automatic get_byte(input logic nack, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_c(1'b1, s);
      b[i] = s;
    end
    bit_c(nack, s);
  endtask : get_byte
  // stop: sda rises while scl is high
  task automatic stop_c();
    #(HALF / 2) sda_o = 1'b0;
    #(HALF / 2) scl_o = 1'b1;
    #HALF sda_o = 1'b1;
  endtask : stop_c
endmodule : mac_i2c_host

// ==== tb/tb_mac_trim_ctrl.sv ====
/*
  self-checking bench of the margin adjust control block.
  assumes the host model and shortened interval and calibration counts.
*/
`include "mac_map.svh"
`define CHK(what, exp, got) \
  begin \
    checks++; \
    if ((got) !== (exp)) begin \
      miscompares++; \
      $display("wrong value %s expected %h seen %h", what, exp, got); \
    end \
  end
module tb_mac_trim_ctrl;
  timeunit 1ns;
  timeprecision 1ns;
  import mac_pkg::*;
  localparam int         UPD [4] = '{20, 30, 40, 50};
  localparam int         CAL     = 20;
  localparam logic [6:0] ADDR    = 7'h4a;
  logic               clk_i = 1'b0, rst_i = 1'b1, pin_rst_n = 1'b1, jtag_rst = 1'b0;
  logic [1:0]         ps_pin = '0, ps_log = '0, rate = '0, ofs = 2'b01;
  logic               from_log = 1'b0, cl_en = 1'b0, alert_req = 1'b0, ce = 1'b1;
  logic [15:0]        lv_lvl = 16'h00f0;
  logic [3:0]         hv_lvl = 4'b1010, hv_fet = 4'b0011;
  mac_cell_nv_s [7:0] cell_nv;
  mac_adc_s           adc = '0;
  int                 miscompares = 0, checks = 0;
  wire logic          host_scl, host_sda, sda_w;
  logic               sda_o, sda_oe, alert_o, alert_oe, dac_rdy, seq_rs;
  logic [15:0]        lv_oe;
  logic [3:0]         hv_o, hv_oe;
  logic [7:0][7:0]    dac;
  logic [1:0]         ofs_o;
  // wired level with pull-up: low while either side pulls
  assign sda_w = host_sda & ~sda_oe;
  always #50 clk_i = ~clk_i;
  mac_i2c_host host_inst (.clk_i(clk_i), .sda_i(sda_w), .scl_o(host_scl), .sda_o(host_sda));
  mac_trim_ctrl #(.UPD0_CYC(20), .UPD1_CYC(30), .UPD2_CYC(40), .UPD3_CYC(50),
    .CAL_CYC(CAL), .TO_CYC(200)) mac_trim_ctrl_inst (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce),
    .active_low_reset_pin_i(pin_rst_n), .jtag_reset_i(jtag_rst),
    .profile_select_pin_0_i(ps_pin[0]), .profile_select_pin_1_i(ps_pin[1]),
    .logic_profile_select_0_i(ps_log[0]), .logic_profile_select_1_i(ps_log[1]),
    .closed_loop_enable_i(cl_en), .nv_profile_from_logic_i(from_log),
    .nv_update_rate_i(rate), .nv_offset_sel_i(ofs), .nv_cell_i(cell_nv),
    .slave_addr_i(ADDR), .adc_i(adc), .scl_i(host_scl), .sda_i(sda_w),
    .sda_o(sda_o), .sda_oe_o(sda_oe), .alert_req_i(alert_req), .alert_o(alert_o),
    .alert_oe_o(alert_oe), .lv_level_i(lv_lvl), .hv_level_i(hv_lvl),
    .hv_fet_mode_i(hv_fet), .low_voltage_outputs_oe_o(lv_oe),
    .high_voltage_output_o(hv_o), .high_voltage_output_oe_o(hv_oe),
    .dac_code_o(dac), .dac_ready_o(dac_rdy), .offset_sel_o(ofs_o),
    .seq_restart_o(seq_rs));
  // ----------------------------------------
  // bus and stimulus tasks
  // ----------------------------------------
  task automatic wr(input logic [7:0] ptr, input logic [7:0] d);
    logic a0, a1, a2;
    host_inst.start_c();
    host_inst.put_byte({ADDR, 1'b0}, a0);
    host_inst.put_byte(ptr, a1);
    host_inst.put_byte(d, a2);
    host_inst.stop_c();
    `CHK("write acks", 3'b000, {a0, a1, a2})
  endtask : wr
  // pointer set, then a separate read transfer
  task automatic rd(input logic [7:0] ptr, output logic [7:0] v);
    logic a0, a1, a2;
    host_inst.start_c();
    host_inst.put_byte({ADDR, 1'b0}, a0);
    host_inst.put_byte(ptr, a1);
    host_inst.stop_c();
    host_inst.start_c();
    host_inst.put_byte({ADDR, 1'b1}, a2);
    host_inst.get_byte(1'b1, v);
    host_inst.stop_c();
    `CHK("read acks", 3'b000, {a0, a1, a2})
  endtask : rd
  task automatic feed(input logic [3:0] ch, input logic [9:0] code);
    @(negedge clk_i);
    adc = '{valid: 1'b1, chan: ch, code: code};
    @(negedge clk_i);
    adc.valid = 1'b0;
  endtask : feed
  task automatic report_and_stop();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : report_and_stop
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_profile();
    for (int p = 1; p < 4; p++) begin
      @(negedge clk_i);
      ps_pin = 2'(p);
      ps_log = ~2'(p);
      repeat (6) @(negedge clk_i);
      for (int i = 0; i < 8; i++) `CHK("profile code", 8'(8'h30 + 8'h10 * p + i), dac[i])
    end
    from_log = 1'b1;
    ps_pin = 2'b00;
    ps_log = 2'b10;
    repeat (6) @(negedge clk_i);
    `CHK("logic profile", 8'h57, dac[7])
    ps_log = 2'b00;
    repeat (6) @(negedge clk_i);
    for (int i = 0; i < 8; i++) `CHK("normal profile", (i == 0 || i > 5) ? 8'(8'h30 + i) : 8'h80, dac[i])
    from_log = 1'b0;
  endtask : t_profile
  task automatic t_serial();
    logic [7:0] v;
    logic       a;
    rd(8'h14, v);
    `CHK("serial power-on code", `MAC_ZERO_CODE, v)
    wr(8'h14, 8'h3c); // code in place before its supply is enabled
    `CHK("serial code drives dac", 8'h3c, dac[1])
    rd(8'h14, v);
    `CHK("serial readback", 8'h3c, v)
    rd(8'h05, v);
    `CHK("unmapped read", `MAC_READ_FILL, v)
    host_inst.start_c();
    host_inst.put_byte({ADDR ^ 7'h01, 1'b0}, a);
    host_inst.stop_c();
    `CHK("foreign address", 1'b1, a)
  endtask : t_serial
  // cell 4 uses input 4 which lies above setpoint, unlike input 2
  task automatic t_loop();
    logic [7:0] last;
    wr(8'h15, 8'hfe);
    wr(8'h16, 8'h01);
    feed(4'd2, 10'h100);
    feed(4'd3, 10'h100);
    feed(4'd4, 10'h300);
    feed(4'd5, 10'h200);
    repeat (3 * UPD[0]) @(negedge clk_i);
    `CHK("preload held while disabled", 16'hfe01, {dac[2], dac[3]})
    cl_en = 1'b1;
    repeat (4 * UPD[0]) @(negedge clk_i);
    `CHK("saturated steps", 16'hff00, {dac[2], dac[3]})
    `CHK("equal holds", 8'h80, dac[5])
    `CHK("own input falls", 1'b1, dac[4] < 8'h80)
    // clock enable low must freeze the loop across several intervals
    last = dac[4];
    ce = 1'b0;
    repeat (3 * UPD[0]) @(negedge clk_i);
    `CHK("frozen by enable", last, dac[4])
    ce = 1'b1;
  endtask : t_loop
  task automatic t_rate();
    int         n;
    logic [7:0] last;
    for (int r = 0; r < 4; r++) begin
      @(negedge clk_i);
      rate = 2'(r);
      for (int k = 0; k < 3; k++) begin
        last = dac[4];
        for (n = 1; n < 200 && dac[4] === last; n++) @(negedge clk_i);
      end
      `CHK("update interval", UPD[r], n - 1)
    end
  endtask : t_rate
  // kind 0 pin, 1 jtag, 2 serial reset command
  task automatic t_reset(input int kind);
    logic [7:0] v;
    int         n;
    wr(8'h14, 8'h3c);
    @(negedge clk_i);
    alert_req = 1'b1;
    ofs = 2'(kind + 2);
    repeat (2) @(negedge clk_i);
    `CHK("alert follows", 1'b1, alert_oe)
    `CHK("offset fixed in run", 2'(kind + 1), ofs_o)
    `CHK("configured outputs", {~lv_lvl, 8'h72}, {lv_oe, hv_oe, hv_o})
    case (kind)
      0: pin_rst_n = 1'b0;
      1: jtag_rst = 1'b1;
      default: wr(8'h12, 8'h00);
    endcase
    if (kind < 2) begin
      repeat (5) @(negedge clk_i);
      `CHK("outputs in reset", {16'h0, 8'h30, 1'b0}, {lv_oe, hv_oe, hv_o, alert_oe})
      pin_rst_n = 1'b1;
      jtag_rst = 1'b0;
    end
    for (n = 0; n < 100 && seq_rs !== 1'b1; n++) @(negedge clk_i);
    `CHK("sequence restart", 1'b1, seq_rs)
    for (n = 0; n < 100 && dac_rdy !== 1'b1; n++) @(negedge clk_i);
    `CHK("calibration time", 1'b1, n >= CAL - 3 && n <= CAL + 2)
    `CHK("offset latched", 2'(kind + 2), ofs_o)
    alert_req = 1'b0;
    rd(8'h14, v);
    `CHK("power-on state", `MAC_ZERO_CODE, v)
  endtask : t_reset
  // ----------------------------------------
  // main sequence and watchdog
  // ----------------------------------------
  initial begin
    for (int i = 0; i < 8; i++) begin
      cell_nv[i].mode = (i == 1) ? MAC_MODE_I2C : (i > 1 && i < 6) ? MAC_MODE_CL :
                        (i == 6) ? mac_mode_e'(2'b11) : MAC_MODE_NV0;
      cell_nv[i].pol = (i == 3);
      cell_nv[i].setpoint = 10'h200;
      for (int k = 0; k < 4; k++) cell_nv[i].dac[k] = 8'(8'h30 + 8'h10 * k + i);
    end
    repeat (8) @(negedge clk_i);
    `CHK("codes in reset", {8{`MAC_ZERO_CODE}}, dac)
    `CHK("pins float in reset", 21'h0, {lv_oe, hv_oe, sda_oe})
    rst_i = 1'b0;
    for (int n = 0; n < 100 && dac_rdy !== 1'b1; n++) @(negedge clk_i);
    `CHK("calibrated", 1'b1, dac_rdy)
    t_profile();
    t_serial();
    t_loop();
    t_rate();
    for (int k = 0; k < 3; k++) t_reset(k);
    report_and_stop();
  end
  // cuts a hang short: the run needs about 0.5 ms
  initial begin
    #3000000;
    miscompares++;
    report_and_stop();
  end
endmodule : tb_mac_trim_ctrl
